// *** common/overlap_pkg.sv ***
// constants, types and helpers for the back-to-back overlap stall logic
//
// How it works
// - after each dram cycle a precharge interval blocks launching another dram access
// - ssram transactions never wait on precharge left by an earlier dram cycle
// - a dram request during open precharge holds the processor until launch is legal
// - stall counts are defined for back-to-back, one idle cycle between transactions
// - anything following an ssram transaction gets no overlap stall
// - anything following an i/o transaction gets no overlap stall
// - a dram access after an edo read or write gets one extra stall
// - ssram or i/o after an edo read or write gets no extra stall
// - a dram access after a burst-edo read gets one extra stall
// - ssram or i/o after a burst-edo read gets no extra stall
// - a dram access after a burst-edo write gets two extra stalls
// - ssram or i/o after a burst-edo write gets no extra stall
// - burst-edo write adds a recovery cycle, seen only by a following dram cycle
package overlap_pkg;

    // ****************************************************************
    // transaction kinds
    // ****************************************************************
    typedef enum logic [1:0] {
        KIND_SSRAM,
        KIND_IO,
        KIND_EDO,
        KIND_BEDO
    } kind_e;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int TMR_W = 3;
    localparam logic [TMR_W-1:0] TMR_ZERO = 3'h0;
    localparam logic [TMR_W-1:0] TMR_ONE = 3'h1;
    // idle bus cycles between two back-to-back transactions
    localparam logic [TMR_W-1:0] B2B_IDLE = 3'h1;
    localparam logic [TMR_W-1:0] PEN_NONE = 3'h0;
    localparam logic [TMR_W-1:0] PEN_EDO = 3'h1;
    localparam logic [TMR_W-1:0] PEN_BEDO_RD = 3'h1;
    // one more than a burst-edo read: the recovery cycle before ras negates
    localparam logic [TMR_W-1:0] PEN_BEDO_WR = 3'h2;

    function automatic logic is_dram(input kind_e kind);
        return (kind == KIND_EDO) || (kind == KIND_BEDO);
    endfunction

    // extra stalls a dram access sees when it follows this kind back to back
    function automatic logic [TMR_W-1:0] overlap_pen(input kind_e kind,
                                                     input logic write);
        logic [TMR_W-1:0] pen;
        pen = PEN_NONE;
        if (kind == KIND_EDO) begin
            pen = PEN_EDO;
        end else if (kind == KIND_BEDO) begin
            pen = write ? PEN_BEDO_WR : PEN_BEDO_RD;
        end
        return pen;
    endfunction

endpackage

// *** hdl/precharge_timer.sv ***
// down counter that measures the remaining ras precharge interval
`timescale 1ns/1ps
module precharge_timer
    import overlap_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [TMR_W-1:0] load_val,
    output logic [TMR_W-1:0] count,
    output logic expired
);

    logic [TMR_W-1:0] count_r;
    logic [TMR_W-1:0] count_nxt;

    assign count_nxt = load ? load_val :
                       (count_r == TMR_ZERO) ? TMR_ZERO :
                       count_r - TMR_ONE;
    assign count = count_r;
    assign expired = (count_r == TMR_ZERO);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= TMR_ZERO;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule // precharge_timer

// *** hdl/overlap_stall.sv ***
// overlap stall insertion between back-to-back processor bus transactions
`timescale 1ns/1ps
module overlap_stall
    import overlap_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire kind_e req_kind,
    input wire logic req_write,
    input wire logic txn_done,
    output logic go_ssram_r,
    output logic go_io_r,
    output logic go_dram_r,
    output logic go_write_r,
    output kind_e go_kind_r,
    output logic overlap_stall_r,
    output logic busy_r,
    output kind_e last_kind_r,
    output logic last_write_r,
    output logic [TMR_W-1:0] last_pen_r
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD,
        ST_BUSY
    } state_e;

    state_e state_r;
    state_e state_nxt;
    kind_e cur_kind_r;
    logic cur_write_r;
    kind_e hold_kind_r;
    logic hold_write_r;
    logic [TMR_W-1:0] stall_cnt_r;
    logic [TMR_W-1:0] stall_cnt_nxt;

    logic prech_expired;
    logic prech_load;
    logic [TMR_W-1:0] prech_val;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire accept = (state_r == ST_IDLE) && req_valid;
    wire req_dram = is_dram(req_kind);
    // ssram and i/o never look at the precharge timer
    wire launch_now = accept &&
        (!req_dram || prech_expired);
    wire must_hold = accept && req_dram && !prech_expired;
    wire hold_release = (state_r == ST_HOLD) && prech_expired;
    wire launch = launch_now || hold_release;
    wire kind_e launch_kind = hold_release ? hold_kind_r : req_kind;
    wire launch_write = hold_release ? hold_write_r : req_write;
    wire finish = (state_r == ST_BUSY) && txn_done;

    // only dram cycles leave precharge behind; the idle cycle of a
    // back-to-back pair already covers part of it
    assign prech_load = finish && is_dram(cur_kind_r);
    assign prech_val = overlap_pen(cur_kind_r, cur_write_r) + B2B_IDLE;

    assign stall_cnt_nxt = must_hold ? TMR_ZERO :
                           (state_r == ST_HOLD) ? stall_cnt_r + TMR_ONE :
                           stall_cnt_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (launch_now) begin
                    state_nxt = ST_BUSY;
                end else if (must_hold) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (hold_release) begin
                    state_nxt = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (txn_done) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    precharge_timer u_prech (
        .core_clk(core_clk),
        .resetn(resetn),
        .load(prech_load),
        .load_val(prech_val),
        .count(),
        .expired(prech_expired)
    );

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            stall_cnt_r <= TMR_ZERO;
        end else begin
            state_r <= state_nxt;
            stall_cnt_r <= stall_cnt_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hold_kind_r <= KIND_SSRAM;
            hold_write_r <= 1'b0;
        end else if (must_hold) begin
            hold_kind_r <= req_kind;
            hold_write_r <= req_write;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cur_kind_r <= KIND_SSRAM;
            cur_write_r <= 1'b0;
        end else if (launch) begin
            cur_kind_r <= launch_kind;
            cur_write_r <= launch_write;
        end
    end

    // launch strobes to the sequencers, one cycle each; go_kind_r holds the last launched kind
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            go_ssram_r <= 1'b0;
            go_io_r <= 1'b0;
            go_dram_r <= 1'b0;
            go_write_r <= 1'b0;
            go_kind_r <= KIND_SSRAM;
        end else begin
            go_ssram_r <= launch && (launch_kind == KIND_SSRAM);
            go_io_r <= launch && (launch_kind == KIND_IO);
            go_dram_r <= launch && is_dram(launch_kind);
            go_write_r <= launch && launch_write;
            go_kind_r <= launch ? launch_kind : go_kind_r;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            overlap_stall_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            overlap_stall_r <= (state_nxt == ST_HOLD);
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    // history of the finished transaction and the penalty it hands on
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            last_kind_r <= KIND_SSRAM;
            last_write_r <= 1'b0;
            last_pen_r <= PEN_NONE;
        end else if (finish) begin
            last_kind_r <= cur_kind_r;
            last_write_r <= cur_write_r;
            last_pen_r <= overlap_pen(cur_kind_r, cur_write_r);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // finish of a given dram kind, one idle cycle, then a dram request
    sequence s_b2b_dram(kind_e k, logic w);
        finish && cur_kind_r == k && cur_write_r == w
        ##1 !req_valid
        ##1 req_valid && is_dram(req_kind);
    endsequence

    sequence s_b2b_other(kind_e k);
        finish && cur_kind_r == k
        ##1 !req_valid
        ##1 req_valid && !is_dram(req_kind);
    endsequence

    a_dram_launch_clear: assert property (
        @(posedge core_clk) disable iff (!resetn)
        finish && is_dram(cur_kind_r) |=> (!go_dram_r) [*3]
    ) else $error("dram launched inside precharge");

    a_ssram_no_wait: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && req_kind == KIND_SSRAM |=> go_ssram_r && !overlap_stall_r
    ) else $error("ssram request was delayed");

    a_hold_stalls_cpu: assert property (
        @(posedge core_clk) disable iff (!resetn)
        must_hold |=> overlap_stall_r && !go_dram_r
    ) else $error("held dram request did not stall");

    a_hold_ends_launch: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $fell(overlap_stall_r) |-> go_dram_r
    ) else $error("stall ended without dram launch");

    a_edo_one_stall: assert property (
        @(posedge core_clk) disable iff (!resetn)
        s_b2b_dram(KIND_EDO, 1'b0) or s_b2b_dram(KIND_EDO, 1'b1)
        |=> !go_dram_r ##1 go_dram_r
    ) else $error("edo to dram was not one stall");

    a_bedo_rd_one: assert property (
        @(posedge core_clk) disable iff (!resetn)
        s_b2b_dram(KIND_BEDO, 1'b0) |=> !go_dram_r ##1 go_dram_r
    ) else $error("bedo read to dram was not one stall");

    a_bedo_wr_two: assert property (
        @(posedge core_clk) disable iff (!resetn)
        s_b2b_dram(KIND_BEDO, 1'b1)
        |=> overlap_stall_r [*2] ##1 go_dram_r
    ) else $error("bedo write to dram was not two stalls");

    a_bedo_wr_count: assert property (
        @(posedge core_clk) disable iff (!resetn)
        s_b2b_dram(KIND_BEDO, 1'b1) |=> ##2 stall_cnt_r == PEN_BEDO_WR
    ) else $error("bedo write recovery not counted");

    a_dram_to_other: assert property (
        @(posedge core_clk) disable iff (!resetn)
        s_b2b_other(KIND_EDO) or s_b2b_other(KIND_BEDO)
        |=> (go_ssram_r || go_io_r) && !overlap_stall_r
    ) else $error("ssram or io after dram was stalled");

    a_after_ssram_io: assert property (
        @(posedge core_clk) disable iff (!resetn)
        finish && !is_dram(cur_kind_r) && prech_expired
        ##1 !req_valid ##1 req_valid
        |=> !overlap_stall_r
    ) else $error("stall after ssram or io");

    a_io_no_wait: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && req_kind == KIND_IO |=> go_io_r ##1 busy_r
    ) else $error("io request was delayed");

    a_history_kept: assert property (
        @(posedge core_clk) disable iff (!resetn)
        finish |=> last_kind_r == $past(cur_kind_r)
                   && last_write_r == $past(cur_write_r)
    ) else $error("last transaction not recorded");

    a_prech_loaded: assert property (
        @(posedge core_clk) disable iff (!resetn)
        finish && is_dram(cur_kind_r) |=> !prech_expired
    ) else $error("no precharge after dram cycle");

    a_busy_until_done: assert property (
        @(posedge core_clk) disable iff (!resetn)
        go_dram_r |-> busy_r [*2]
    ) else $error("busy dropped right after launch");

endmodule // overlap_stall

// *** test/seq_model.sv ***
// sequencer stand-in that ends each launched transaction after a set delay
`timescale 1ns/1ps
module seq_model
    import overlap_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic go_any,
    input wire logic [TMR_W-1:0] lat,
    output logic txn_done
);
    logic [TMR_W-1:0] cnt_r;

    // done never lands in the launch cycle itself, at least one cycle later
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= TMR_ZERO;
            txn_done <= 1'b0;
        end else begin
            txn_done <= (cnt_r == TMR_ONE);
            if (go_any) begin
                cnt_r <= lat;
            end else if (cnt_r != TMR_ZERO) begin
                cnt_r <= cnt_r - TMR_ONE;
            end
        end
    end
endmodule // seq_model

// *** test/tb.sv ***
// self-checking bench for the overlap stall block
`timescale 1ns/1ps
module tb;
    import overlap_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    kind_e req_kind = KIND_SSRAM;
    logic req_write = 1'b0;
    logic [TMR_W-1:0] lat = 3'h1;
    logic txn_done, go_ssram_r, go_io_r, go_dram_r, go_write_r;
    logic overlap_stall_r, busy_r, last_write_r, go_any;
    kind_e go_kind_r, last_kind_r;
    logic [TMR_W-1:0] last_pen_r;
    int failures = 0;
    int checked = 0;

    always #5 core_clk = ~core_clk;
    assign go_any = go_ssram_r | go_io_r | go_dram_r;

    overlap_stall u_dut (.core_clk(core_clk), .resetn(resetn),
        .req_valid(req_valid), .req_kind(req_kind), .req_write(req_write),
        .txn_done(txn_done), .go_ssram_r(go_ssram_r), .go_io_r(go_io_r),
        .go_dram_r(go_dram_r), .go_write_r(go_write_r),
        .go_kind_r(go_kind_r), .overlap_stall_r(overlap_stall_r),
        .busy_r(busy_r), .last_kind_r(last_kind_r),
        .last_write_r(last_write_r), .last_pen_r(last_pen_r));

    seq_model u_seq (.core_clk(core_clk), .resetn(resetn),
        .go_any(go_any), .lat(lat), .txn_done(txn_done));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic final_report();
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic timeout();
        failures++;
        $display("[FAIL] %0t wait limit reached", $time);
        final_report();
    endtask

    // extra stalls the second of a back-to-back pair should see
    function automatic int exp_pen(input kind_e k1, input logic w1,
                                   input kind_e k2);
        if (k2 == KIND_SSRAM || k2 == KIND_IO || k1 == KIND_SSRAM ||
            k1 == KIND_IO) begin
            return 0;
        end
        return (k1 == KIND_BEDO && w1) ? 2 : 1;
    endfunction

    // called just after a rising edge; n counts cycles until the launch
    task automatic launch(input kind_e k, input logic w, output int n,
                          output int st);
        n = 0;
        st = 0;
        req_kind <= k;
        req_write <= w;
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        // the go strobe stands only in the cycle after the launch edge
        #1;
        n = 1;
        if (overlap_stall_r === 1'b1) st++;
        while (go_any !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1;
            n++;
            if (overlap_stall_r === 1'b1) st++;
        end
        if (go_any !== 1'b1) timeout();
        check({go_ssram_r, go_io_r, go_dram_r} === {k == KIND_SSRAM,
            k == KIND_IO, k == KIND_EDO || k == KIND_BEDO}, "go");
        check(go_write_r === w && go_kind_r === k, "go kind");
        check(busy_r === 1'b1, "busy at launch");
    endtask

    task automatic wait_done(output int gos);
        gos = 0;
        for (int i = 0; i < 50; i++) begin
            @(posedge core_clk);
            #1;
            if (go_any === 1'b1) gos++;
            if (txn_done === 1'b1) return;
        end
        timeout();
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic b2b_pair(input kind_e k1, input logic w1,
                            input kind_e k2, input logic w2);
        int n, st, gos, pen;
        pen = exp_pen(k1, w1, k2);
        launch(k1, w1, n, st);
        wait_done(gos);
        @(posedge core_clk);
        #1;
        check(last_kind_r === k1 && last_write_r === w1, "last");
        check(busy_r === 1'b0, "busy after done");
        check(int'(last_pen_r) == exp_pen(k1, w1, KIND_EDO), "pen");
        // one idle cycle, then the follower
        @(posedge core_clk);
        launch(k2, w2, n, st);
        check(n == pen + 1, "launch delay");
        check(st == pen, "stall cycles");
        wait_done(gos);
        repeat (8) @(posedge core_clk);
    endtask

    // a request while busy is dropped, not queued
    task automatic refused_req();
        int n, st, gos;
        lat <= 3'h4;
        launch(KIND_IO, 1'b0, n, st);
        @(posedge core_clk);
        req_kind <= KIND_EDO;
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        wait_done(gos);
        check(gos == 0, "request taken while busy");
        repeat (8) @(posedge core_clk);
        lat <= 3'h1;
        @(posedge core_clk);
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        for (int j = 0; j < 4; j++) begin
            b2b_pair(KIND_SSRAM, 1'b0, kind_e'(j), j[0]);
            b2b_pair(KIND_IO, 1'b1, kind_e'(j), j[0]);
            b2b_pair(KIND_EDO, 1'b0, kind_e'(j), j[1]);
            b2b_pair(KIND_EDO, 1'b1, kind_e'(j), j[0]);
            b2b_pair(KIND_BEDO, 1'b0, kind_e'(j), j[1]);
            b2b_pair(KIND_BEDO, 1'b1, kind_e'(j), j[0]);
        end
        refused_req();
        final_report();
    end
endmodule // tb
